// file: hdl/gpio_pkg.sv
// constants, register map and carrier types for the port 2 / port 5 pin logic
// assumes one 10 MHz system clock and a byte-wide register port from the core
`default_nettype none

package gpio_pkg;

  // ==========================================================================
  // register port
  localparam int ADDR_W = 4;

  localparam logic [3:0] ADDR_P2_DIR  = 4'h0;
  localparam logic [3:0] ADDR_P2_DATA = 4'h1;
  localparam logic [3:0] ADDR_P5_SEL  = 4'h2;
  localparam logic [3:0] ADDR_P5_DIR  = 4'h3;
  localparam logic [3:0] ADDR_P5_DATA = 4'h4;
  localparam logic [3:0] ADDR_P1_SEL  = 4'h5;

  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] WRITE_ONLY_READ = 8'h00;

  // ==========================================================================
  // reset values and fixed read fields
  localparam logic [2:0] P2_DATA_RST = 3'h0;
  localparam logic [2:0] P2_DIR_RST  = 3'h0;
  localparam logic [7:0] P5_DATA_RST = 8'h00;
  localparam logic [7:0] P5_DIR_RST  = 8'h00;
  localparam logic [5:0] P5_SEL_RST  = 6'h00;
  localparam logic       P1_TX_RST   = 1'b0;
  localparam logic [7:0] RDATA_RST   = 8'h00;

  localparam logic [4:0] P2_DATA_FILL = 5'h1f;
  localparam logic [1:0] P5_SEL_FILL  = 2'h0;

  // ==========================================================================
  // field positions
  localparam int P1_TX_BIT   = 1;
  localparam int P2_CLK_PIN  = 0;
  localparam int P2_RX_PIN   = 1;
  localparam int P2_TX_PIN   = 2;
  localparam int P5_SCL_PIN  = 7;
  localparam int P5_SDA_PIN  = 6;
  localparam int P5_TRIG_PIN = 5;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe_n;
  } p2_drive_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } p5_drive_t;

  // state of the serial unit that decides the port 2 pin functions
  typedef struct packed {
    logic receiver_enable_bit;
    logic clock_source_high;
    logic clock_source_low;
    logic comm_mode;
    logic txd;
    logic clk_out;
  } serial_ctl_t;

  typedef struct packed {
    logic rxd;
    logic clk_in;
  } serial_in_t;

  typedef struct packed {
    logic enable;
    logic scl_drive_low;
    logic sda_drive_low;
  } twowire_ctl_t;

endpackage

`default_nettype wire

// file: hdl/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes the pins are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  // first stage is read only by the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta     <= '0;
      pin_sync <= '0;
    end else begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end

endmodule

`default_nettype wire

// file: hdl/port2_port5_gpio_mux.sv
// pin logic of port 2 (serial pins) and port 5 (two-wire, wakeup, trigger)
// assumes serial and two-wire units on mclk; pins asynchronous and synchronised here
//
// How it works
// - port 2 data reads give ones in bits 7..3; writes there are dropped
// - three port 2 output latches, cleared at reset, drive pins set as outputs
// - port 2 data read: latch where direction is 1, pin level where 0
// - transmit select drives pin 2 with serial data; receive enable frees pin 1
// - two-wire enable owns port 5 pins 7 and 6 ahead of port registers
// - port 5 function select reads zero in bits 7 and 6
// - select bit 5 turns pin 5 into wakeup five and converter trigger input
// - select bits 4..0 turn their pins into wakeup inputs; all reset to 0
// - port 5 direction: 1 output, 0 input; write-only, resets to 0
// - port 5 data read: latch where direction is 1, pin level where 0
// - port 2 direction: 1 output, 0 input; write-only, resets to 0
`timescale 1ns/1ps
`default_nettype none

module port2_port5_gpio_mux (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic [gpio_pkg::ADDR_W-1:0]  addr,
  input  wire logic [7:0]                   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [7:0]                   rdata,
  input  wire logic [2:0]                   p2_pin_in,
  output gpio_pkg::p2_drive_t               p2_drive,
  input  wire logic [7:0]                   p5_pin_in,
  output gpio_pkg::p5_drive_t               p5_drive,
  input  wire gpio_pkg::serial_ctl_t        serial_ctl,
  output gpio_pkg::serial_in_t              serial_in,
  input  wire gpio_pkg::twowire_ctl_t       twowire_ctl,
  output logic                              scl_in,
  output logic                              sda_in,
  output logic      [5:0]                   wakeup_in,
  output logic                              converter_trigger_input
);

  // ==========================================================================
  // registers
  logic [2:0] port2_output_data;
  logic [2:0] port2_direction;
  logic [7:0] port5_output_data;
  logic [7:0] port5_direction;
  logic [5:0] port5_function_select;
  logic       port1_tx_select;

  logic       wr_p2_dir;
  logic       wr_p2_data;
  logic       wr_p5_sel;
  logic       wr_p5_dir;
  logic       wr_p5_data;
  logic       wr_p1_sel;

  assign wr_p2_dir  = wr && (addr == gpio_pkg::ADDR_P2_DIR);
  assign wr_p2_data = wr && (addr == gpio_pkg::ADDR_P2_DATA);
  assign wr_p5_sel  = wr && (addr == gpio_pkg::ADDR_P5_SEL);
  assign wr_p5_dir  = wr && (addr == gpio_pkg::ADDR_P5_DIR);
  assign wr_p5_data = wr && (addr == gpio_pkg::ADDR_P5_DATA);
  assign wr_p1_sel  = wr && (addr == gpio_pkg::ADDR_P1_SEL);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port2_output_data <= gpio_pkg::P2_DATA_RST;
    end else if (wr_p2_data) begin
      port2_output_data <= wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port2_direction <= gpio_pkg::P2_DIR_RST;
    end else if (wr_p2_dir) begin
      port2_direction <= wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port5_output_data <= gpio_pkg::P5_DATA_RST;
    end else if (wr_p5_data) begin
      port5_output_data <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port5_direction <= gpio_pkg::P5_DIR_RST;
    end else if (wr_p5_dir) begin
      port5_direction <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port5_function_select <= gpio_pkg::P5_SEL_RST;
    end else if (wr_p5_sel) begin
      port5_function_select <= wdata[5:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port1_tx_select <= gpio_pkg::P1_TX_RST;
    end else if (wr_p1_sel) begin
      port1_tx_select <= wdata[gpio_pkg::P1_TX_BIT];
    end
  end

  // ==========================================================================
  // pin inputs
  logic [2:0] p2_sync;
  logic [7:0] p5_sync;

  pin_sync #(.WIDTH(3)) u_p2_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .pin_in   (p2_pin_in),
    .pin_sync (p2_sync)
  );

  pin_sync #(.WIDTH(8)) u_p5_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .pin_in   (p5_pin_in),
    .pin_sync (p5_sync)
  );

  // ==========================================================================
  // port 2 pin functions
  logic clk_as_input;
  logic clk_as_output;

  assign clk_as_input  = serial_ctl.clock_source_high;
  assign clk_as_output = !serial_ctl.clock_source_high &&
                         (serial_ctl.clock_source_low || serial_ctl.comm_mode);

  always_comb begin
    // general i/o first, alternate functions override the direction bit
    p2_drive.level = port2_output_data;
    p2_drive.oe_n  = ~port2_direction;
    if (port1_tx_select) begin
      p2_drive.level[gpio_pkg::P2_TX_PIN] = serial_ctl.txd;
      p2_drive.oe_n[gpio_pkg::P2_TX_PIN]  = 1'b0;
    end
    if (serial_ctl.receiver_enable_bit) begin
      p2_drive.level[gpio_pkg::P2_RX_PIN] = 1'b0;
      p2_drive.oe_n[gpio_pkg::P2_RX_PIN]  = 1'b1;
    end
    if (clk_as_input) begin
      p2_drive.level[gpio_pkg::P2_CLK_PIN] = 1'b0;
      p2_drive.oe_n[gpio_pkg::P2_CLK_PIN]  = 1'b1;
    end else if (clk_as_output) begin
      p2_drive.level[gpio_pkg::P2_CLK_PIN] = serial_ctl.clk_out;
      p2_drive.oe_n[gpio_pkg::P2_CLK_PIN]  = 1'b0;
    end
  end

  // the serial unit gates these with its own enables, so they pass freely
  assign serial_in.rxd    = p2_sync[gpio_pkg::P2_RX_PIN];
  assign serial_in.clk_in = p2_sync[gpio_pkg::P2_CLK_PIN];

  // ==========================================================================
  // port 5 pin functions
  always_comb begin
    p5_drive.level = port5_output_data;
    p5_drive.oe_n  = ~port5_direction;
    for (int k = 0; k < 6; k++) begin
      if (port5_function_select[k]) begin
        p5_drive.level[k] = 1'b0;
        p5_drive.oe_n[k]  = 1'b1;
      end
    end
    if (twowire_ctl.enable) begin
      // open drain: only ever pulls low, the bus pull-up makes the high
      p5_drive.level[gpio_pkg::P5_SCL_PIN] = 1'b0;
      p5_drive.level[gpio_pkg::P5_SDA_PIN] = 1'b0;
      p5_drive.oe_n[gpio_pkg::P5_SCL_PIN]  = !twowire_ctl.scl_drive_low;
      p5_drive.oe_n[gpio_pkg::P5_SDA_PIN]  = !twowire_ctl.sda_drive_low;
    end
  end

  assign scl_in    = p5_sync[gpio_pkg::P5_SCL_PIN];
  assign sda_in    = p5_sync[gpio_pkg::P5_SDA_PIN];
  assign wakeup_in = p5_sync[5:0] & port5_function_select;
  assign converter_trigger_input = p5_sync[gpio_pkg::P5_TRIG_PIN] &&
                                   port5_function_select[gpio_pkg::P5_TRIG_PIN];

  // ==========================================================================
  // read path
  logic [2:0] p2_read;
  logic [7:0] p5_read;
  logic [7:0] next_rdata;

  assign p2_read = (port2_direction & port2_output_data) | (~port2_direction & p2_sync);
  assign p5_read = (port5_direction & port5_output_data) | (~port5_direction & p5_sync);

  always_comb begin
    case (addr)
      gpio_pkg::ADDR_P2_DIR:  next_rdata = gpio_pkg::WRITE_ONLY_READ;
      gpio_pkg::ADDR_P2_DATA: next_rdata = {gpio_pkg::P2_DATA_FILL, p2_read};
      gpio_pkg::ADDR_P5_SEL:  next_rdata = {gpio_pkg::P5_SEL_FILL,
                                            port5_function_select};
      gpio_pkg::ADDR_P5_DIR:  next_rdata = gpio_pkg::WRITE_ONLY_READ;
      gpio_pkg::ADDR_P5_DATA: next_rdata = p5_read;
      gpio_pkg::ADDR_P1_SEL: begin
        next_rdata = gpio_pkg::UNMAPPED_READ;
        next_rdata[gpio_pkg::P1_TX_BIT] = port1_tx_select;
      end
      default:                next_rdata = gpio_pkg::UNMAPPED_READ;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= gpio_pkg::RDATA_RST;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= gpio_pkg::RDATA_RST;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_p2_upper_ones: assert property (
    rd && addr == gpio_pkg::ADDR_P2_DATA |=> rdata[7:3] == 5'h1f)
    else $error("port 2 data upper bits not read as ones");

  a_p2_latch_drive: assert property (
    wr_p2_data && port2_direction[gpio_pkg::P2_TX_PIN] && !port1_tx_select ##1
    !port1_tx_select |-> !p2_drive.oe_n[2] && p2_drive.level[2] == $past(wdata[2]))
    else $error("port 2 output latch not on pin");

  a_p2_read_mix: assert property (
    rd && addr == gpio_pkg::ADDR_P2_DATA |=>
    rdata[2:0] == (($past(port2_direction) & $past(port2_output_data)) |
                   (~$past(port2_direction) & $past(p2_sync))))
    else $error("port 2 read mix wrong");

  a_tx_route: assert property (
    port1_tx_select |-> !p2_drive.oe_n[2] && p2_drive.level[2] == serial_ctl.txd)
    else $error("transmit pin not driven by serial data");

  a_rx_release: assert property (
    serial_ctl.receiver_enable_bit |-> p2_drive.oe_n[1] &&
    serial_in.rxd == $past(p2_pin_in[1], 2))
    else $error("receive pin not released or not synchronised");

  a_clk_input: assert property (
    serial_ctl.clock_source_high |-> p2_drive.oe_n[0])
    else $error("serial clock pin not released as input");

  a_clk_output: assert property (
    !serial_ctl.clock_source_high && (serial_ctl.clock_source_low || serial_ctl.comm_mode) |->
    !p2_drive.oe_n[0] && p2_drive.level[0] == serial_ctl.clk_out)
    else $error("serial clock pin not driving the clock out");

  a_twowire_own: assert property (
    twowire_ctl.enable |-> p5_drive.level[7:6] == 2'b00 &&
    p5_drive.oe_n[7] == !twowire_ctl.scl_drive_low &&
    p5_drive.oe_n[6] == !twowire_ctl.sda_drive_low)
    else $error("two-wire pins not owned by bus interface");

  a_p5_sel_zero: assert property (
    wr_p5_sel ##1 rd && addr == gpio_pkg::ADDR_P5_SEL |=>
    rdata == {2'b00, $past(wdata[5:0], 2)})
    else $error("port 5 select read back wrong");

  a_trigger_route: assert property (
    port5_function_select[5] |-> p5_drive.oe_n[5] &&
    converter_trigger_input == wakeup_in[5] && wakeup_in[5] == p5_sync[5])
    else $error("pin 5 trigger routing wrong");

  a_wakeup_gate: assert property (
    wakeup_in[4:0] == (p5_sync[4:0] & port5_function_select[4:0]))
    else $error("wakeup inputs not gated by select");

  a_p5_dir_drive: assert property (
    wr_p5_dir && !twowire_ctl.enable && port5_function_select == 6'h00 ##1
    !twowire_ctl.enable && port5_function_select == 6'h00 |->
    p5_drive.oe_n == ~$past(wdata) && rdata == 8'h00)
    else $error("port 5 direction not applied");

  a_p5_read_mix: assert property (
    rd && addr == gpio_pkg::ADDR_P5_DATA |=>
    rdata == (($past(port5_direction) & $past(port5_output_data)) |
              (~$past(port5_direction) & $past(p5_sync))))
    else $error("port 5 read mix wrong");

  a_p2_dir_write: assert property (
    wr_p2_dir |=> port2_direction == $past(wdata[2:0]))
    else $error("port 2 direction not written");

endmodule

`default_nettype wire

// file: tb/pin_world.sv
// model of the board around port 2 and port 5: resolves each pin level
// assumes the bench supplies what outside parts put on released pins
`timescale 1ns/1ps
`default_nettype none

module pin_world (
  input  wire gpio_pkg::p2_drive_t p2_drive,
  input  wire gpio_pkg::p5_drive_t p5_drive,
  input  wire logic [2:0]          p2_ext,
  input  wire logic [7:0]          p5_ext,
  output logic      [2:0]          p2_pin_in,
  output logic      [7:0]          p5_pin_in
);
  // ==========================================================================
  // pin resolution
  // a released pin shows the outside level, never the last driven one;
  // for the open-drain pins 7 and 6 the outside level stands for the pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      p2_pin_in[i] = p2_drive.oe_n[i] ? p2_ext[i] : p2_drive.level[i];
    end
    for (int i = 0; i < 8; i++) begin
      p5_pin_in[i] = p5_drive.oe_n[i] ? p5_ext[i] : p5_drive.level[i];
    end
  end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the port 2 / port 5 pin logic
// assumes the pin model of pin_world and a 10 MHz mclk
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                   mclk;
  logic                   nrst;
  logic [3:0]             addr;
  logic [7:0]             wdata;
  logic                   wr;
  logic                   rd;
  logic [7:0]             rdata;
  logic [2:0]             p2_pin_in;
  logic [7:0]             p5_pin_in;
  logic [2:0]             p2_ext;
  logic [7:0]             p5_ext;
  logic                   scl_in;
  logic                   sda_in;
  logic [5:0]             wakeup_in;
  logic                   converter_trigger_input;
  gpio_pkg::p2_drive_t    p2_drive;
  gpio_pkg::p5_drive_t    p5_drive;
  gpio_pkg::serial_ctl_t  serial_ctl;
  gpio_pkg::serial_in_t   serial_in;
  gpio_pkg::twowire_ctl_t twowire_ctl;
  int                     bad_count;
  int                     comparisons;

  port2_port5_gpio_mux u_port2_port5_gpio_mux (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .p2_pin_in(p2_pin_in), .p2_drive(p2_drive),
    .p5_pin_in(p5_pin_in), .p5_drive(p5_drive), .serial_ctl(serial_ctl),
    .serial_in(serial_in), .twowire_ctl(twowire_ctl), .scl_in(scl_in),
    .sda_in(sda_in), .wakeup_in(wakeup_in),
    .converter_trigger_input(converter_trigger_input));

  pin_world u_pin_world (
    .p2_drive(p2_drive), .p5_drive(p5_drive), .p2_ext(p2_ext), .p5_ext(p5_ext),
    .p2_pin_in(p2_pin_in), .p5_pin_in(p5_pin_in));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_rchk(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask

  // pins reach reads and outputs two edges after they change
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    check({13'h0, p2_drive.oe_n}, 16'h0007);
    check({8'h0, p5_drive.oe_n}, 16'h00ff);
    rchk(gpio_pkg::ADDR_P2_DATA, 8'hf8);
    rchk(gpio_pkg::ADDR_P2_DIR, 8'h00);
    rchk(gpio_pkg::ADDR_P5_SEL, 8'h00);
    rchk(gpio_pkg::ADDR_P5_DIR, 8'h00);
    rchk(gpio_pkg::ADDR_P5_DATA, 8'hc3);
    rchk(4'hf, 8'h00);
  endtask

  task automatic t_port2();
    wr_reg(gpio_pkg::ADDR_P2_DATA, 8'hff);
    rchk(gpio_pkg::ADDR_P2_DATA, 8'hf8);
    wr_reg(gpio_pkg::ADDR_P2_DIR, 8'h05);
    check({13'h0, p2_drive.oe_n}, 16'h0002);
    check({15'h0, p2_drive.level[2]}, 16'h0001);
    p2_ext <= 3'b010;
    settle();
    rchk(gpio_pkg::ADDR_P2_DATA, 8'hff);
    // latch bit 1 is 0 while the input pin 1 sits at 1
    wr_reg(gpio_pkg::ADDR_P2_DATA, 8'h00);
    rchk(gpio_pkg::ADDR_P2_DATA, 8'hfa);
    check({15'h0, p2_drive.level[0]}, 16'h0000);
  endtask

  task automatic t_serial();
    logic [2:0] mode [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    wr_reg(gpio_pkg::ADDR_P1_SEL, 8'h02);
    @(posedge mclk);
    serial_ctl.txd <= 1'b1;
    #1;
    check({p2_drive.oe_n[2], p2_drive.level[2]}, 16'h0001);
    wr_reg(gpio_pkg::ADDR_P2_DIR, 8'h07);
    @(posedge mclk);
    serial_ctl.receiver_enable_bit <= 1'b1;
    // latch bit 1 holds 0, so only a released pin shows the outside 1
    p2_ext <= 3'b010;
    settle();
    check({15'h0, p2_drive.oe_n[1]}, 16'h0001);
    check({15'h0, serial_in.rxd}, 16'h0001);
    @(posedge mclk);
    serial_ctl.clk_out <= 1'b1;
    p2_ext <= 3'b001;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {serial_ctl.clock_source_high, serial_ctl.clock_source_low,
       serial_ctl.comm_mode} <= mode[i];
      settle();
      check({15'h0, p2_drive.oe_n[0]}, (i == 0) ? 16'h1 : 16'h0);
      if (i == 0) check({15'h0, serial_in.clk_in}, 16'h0001);
      if (i != 0) check({15'h0, p2_drive.level[0]}, (i < 3) ? 16'h1 : 16'h0);
    end
  endtask

  task automatic t_port5();
    // bits 7 and 6 of direction and data stay 0 as on the reduced variant
    wr_reg(gpio_pkg::ADDR_P5_DIR, 8'h3f);
    rchk(gpio_pkg::ADDR_P5_DIR, 8'h00);
    check({8'h0, p5_drive.oe_n}, 16'h00c0);
    wr_rchk(gpio_pkg::ADDR_P5_SEL, 8'hff, 8'h3f);
    wr_reg(gpio_pkg::ADDR_P5_DATA, 8'h15);
    p5_ext <= 8'h2a;
    settle();
    check({8'h0, p5_drive.oe_n}, 16'h00ff);
    check({10'h0, wakeup_in}, 16'h002a);
    check({15'h0, converter_trigger_input}, 16'h0001);
    rchk(gpio_pkg::ADDR_P5_DATA, 8'h15);
    wr_reg(gpio_pkg::ADDR_P5_SEL, 8'h00);
    check({8'h0, p5_drive.oe_n}, 16'h00c0);
    check({10'h0, p5_drive.level[5:0]}, 16'h0015);
    settle();
    check({9'h0, wakeup_in, converter_trigger_input}, 16'h0000);
  endtask

  task automatic t_twowire();
    @(posedge mclk);
    p5_ext <= 8'hff;
    twowire_ctl <= '{enable: 1'b1, scl_drive_low: 1'b1, sda_drive_low: 1'b0};
    settle();
    check({p5_drive.oe_n[7:6], p5_drive.level[7]}, 16'h0002);
    check({scl_in, sda_in}, 16'h0001);
  endtask

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    nrst        = 1'b0;
    addr        = 4'h0;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    p2_ext      = 3'b000;
    p5_ext      = 8'hc3;
    serial_ctl  = '0;
    twowire_ctl = '0;
    bad_count   = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    t_reset();
    t_port2();
    t_serial();
    t_port5();
    t_twowire();
    give_verdict();
  end

  // a hang would otherwise run forever; it counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    $display("Error at %0t: run did not finish in time", $time);
    bad_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
